// ===== ledr_pkg.sv
// Purpose: constants and carriers for the leading edge detect block
// Assumes: APB register access, 32-bit data, word per register
// Notes:   register index times four gives the byte address
package ledr_pkg;
  // register indices (byte address = index * 4)
  localparam logic [15:0] IDX_THRESH = 16'h0000;
  localparam logic [15:0] IDX_CFG1   = 16'h0806;
  localparam logic [15:0] IDX_PPINDX = 16'h1000;
  localparam logic [15:0] IDX_PPAMPL = 16'h1002;
  localparam logic [15:0] IDX_ANTD   = 16'h1804;
  localparam logic [15:0] IDX_CFG2   = 16'h1806;
  localparam logic [15:0] IDX_REPC   = 16'h2804;
  localparam logic [15:0] IDX_STATUS = 16'h3000;
  // config one field positions and reset
  localparam int          NTM_LSB    = 0;
  localparam int          NTM_MSB    = 4;
  localparam int          PEAK_NOISE_MULTIPLIER_LSB  = 5;
  localparam int          PEAK_NOISE_MULTIPLIER_MSB  = 7;
  localparam logic [7:0]  CFG1_RST   = 8'h6C;
  localparam logic [15:0] ANTD_RST   = 16'h0000;
  localparam logic [15:0] CFG2_RST   = 16'h0000;
  localparam logic [15:0] REPC_RST   = 16'h0000;
  // one accumulator tap is 64 system-time units (1.0016 ns)
  localparam int          TAP_SHIFT  = 6;
  localparam int          TS_W       = 40;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] mag;
  } ledr_sample_t;

  typedef struct packed {
    logic        found;
    logic [15:0] first_idx;
    logic [15:0] first_amp;
    logic [15:0] threshold;
  } ledr_diag_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_FIN  = 3'b100
  } ledr_state_t;
endpackage

// ===== ledr_top.sv
// Purpose: leading edge detection with APB register file
// Assumes: accumulator taps streamed in after reception, one per valid
// Notes:   APB answers with one wait state; pslverr on unmapped index
// Operation
// [RQ1] scan accumulator taps after reception to find the first path
// [RQ2] compute receive timestamp from first path and output it
// [RQ3] output diagnostics derived from the accumulator analysis
// [RQ4] host writes only defined byte locations of the register file
// [RQ5] first path threshold is noise level times 5-bit multiplier, reset 12
// [RQ6] host may set noise multiplier to 13 for close line-of-sight work
// [RQ7] noise peak raised by 3-bit multiplier over two, reset 3 meaning 1.5
// [RQ8] host writes config one one byte per access only
// [RQ9] record 16-bit index of largest magnitude tap, read only
// [RQ10] record 16-bit magnitude at that peak index, read only
// [RQ11] hold 16-bit read-write receive antenna delay
// [RQ12] antenna delay unit is system time, about 15.65 ps per bit
// [RQ13] subtract antenna delay from raw timestamp
// [RQ14] also correct timestamp for first path position
// [RQ15] results update only when analysis ends and hold until the next
//
// Design decision made here: register access over APB.
module ledr_top
  import ledr_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_sys_rst,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [17:0]     i_paddr,
  input  wire logic [31:0]     i_pwdata,
  input  wire logic [3:0]      i_pstrb,
  output logic      [31:0]     o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic            i_rx_start,
  input  wire logic [15:0]     i_noise_level,
  input  wire logic [15:0]     i_noise_peak,
  input  wire logic [TS_W-1:0] i_raw_ts,
  input  wire ledr_sample_t    i_sample,
  output logic      [TS_W-1:0] o_rx_stamp,
  output ledr_diag_t           o_diag,
  output logic                 o_done,
  output logic                 o_busy
);
  ledr_state_t      state_reg;
  ledr_state_t      state_next;
  logic [7:0]       cfg1_reg;
  logic [15:0]      antd_reg;
  logic [15:0]      cfg2_reg;
  logic [15:0]      repc_reg;
  logic [15:0]      ppindx_reg;
  logic [15:0]      ppampl_reg;
  logic [20:0]      thresh_reg;
  logic [TS_W-1:0]  raw_reg;
  logic [15:0]      cnt_reg;
  logic [15:0]      pidx_run_reg;
  logic [15:0]      pamp_run_reg;
  logic [15:0]      fidx_reg;
  logic [15:0]      famp_reg;
  logic             found_reg;

  // apb decode
  wire [15:0] addr_idx  = i_paddr[17:2];
  wire        acc_ph    = i_psel & i_penable;
  wire        xfer      = acc_ph & o_pready;
  wire        hit_thr   = addr_idx == IDX_THRESH;
  wire        hit_cfg1  = addr_idx == IDX_CFG1;
  wire        hit_pidx  = addr_idx == IDX_PPINDX;
  wire        hit_pamp  = addr_idx == IDX_PPAMPL;
  wire        hit_antd  = addr_idx == IDX_ANTD;
  wire        hit_cfg2  = addr_idx == IDX_CFG2;
  wire        hit_repc  = addr_idx == IDX_REPC;
  wire        hit_stat  = addr_idx == IDX_STATUS;
  wire        mapped    = hit_thr | hit_cfg1 | hit_pidx | hit_pamp |
                          hit_antd | hit_cfg2 | hit_repc | hit_stat;
  wire        wr_ok     = xfer & i_pwrite;
  // config one takes only its own byte lane, one octet per write
  wire        wr_cfg1   = wr_ok & hit_cfg1 & i_pstrb[0]; // RQ8

  // threshold: larger of noise*ntm and noise peak*peak_noise_multiplier/2
  wire [4:0]  noise_threshold_multiplier       = cfg1_reg[NTM_MSB:NTM_LSB];
  wire [2:0]  peak_noise_multiplier     = cfg1_reg[PEAK_NOISE_MULTIPLIER_MSB:PEAK_NOISE_MULTIPLIER_LSB];
  wire [20:0] thr_noise = {5'h00, i_noise_level} * {16'h0000, noise_threshold_multiplier}; // RQ5
  wire [18:0] pk_prod   = {3'h0, i_noise_peak} * {16'h0000, peak_noise_multiplier};
  wire [20:0] thr_peak  = {3'h0, pk_prod[18:1]}; // RQ7
  wire [20:0] thr_calc  = (thr_noise > thr_peak) ? thr_noise : thr_peak;
  wire [15:0] thr_sat   = (|thresh_reg[20:16]) ? 16'hFFFF : thresh_reg[15:0];

  // tap scan terms
  wire        tap       = (state_reg == ST_SCAN) & i_sample.valid;
  wire        new_peak  = tap & (i_sample.mag > pamp_run_reg);
  wire        crossing  = tap & ~found_reg & ({5'h00, i_sample.mag} > thresh_reg);
  wire [15:0] pidx_fin  = new_peak ? cnt_reg : pidx_run_reg;
  wire [15:0] fidx_sel  = found_reg ? fidx_reg : pidx_run_reg;
  wire [15:0] famp_sel  = found_reg ? famp_reg : pamp_run_reg;
  wire [15:0] fp_delta  = pidx_run_reg - fidx_sel;
  // unit of antd and stamp is 1/(499.2 MHz*128) ~ 15.65 ps
  wire [TS_W-1:0] antd_ext  = {{(TS_W-16){1'b0}}, antd_reg}; // RQ12
  wire [TS_W-1:0] fp_corr   = {{(TS_W-16-TAP_SHIFT){1'b0}}, fp_delta, {TAP_SHIFT{1'b0}}};
  wire [TS_W-1:0] stamp_val = raw_reg - antd_ext - fp_corr; // RQ13 RQ14

  // read mux
  wire [31:0] rd_val =
    hit_thr  ? {16'h0000, thr_sat} :
    hit_cfg1 ? {24'h000000, cfg1_reg} :
    hit_pidx ? {16'h0000, ppindx_reg} :
    hit_pamp ? {16'h0000, ppampl_reg} :
    hit_antd ? {16'h0000, antd_reg} :
    hit_cfg2 ? {16'h0000, cfg2_reg} :
    hit_repc ? {16'h0000, repc_reg} :
    hit_stat ? {14'h0000, found_reg, o_busy, fidx_reg} : 32'h0000_0000;

  // lane merge for 16-bit writable registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // apb handshake: one wait state, registered answer
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc_ph & ~o_pready;
      o_pslverr <= acc_ph & ~o_pready & ~mapped;
      o_prdata  <= (acc_ph & ~o_pready & ~i_pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // writable configuration; read-only indices ignore writes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg1_reg <= CFG1_RST; // RQ5 RQ7
      antd_reg <= ANTD_RST;
      cfg2_reg <= CFG2_RST;
      repc_reg <= REPC_RST;
    end else begin
      if (wr_cfg1) cfg1_reg <= i_pwdata[7:0];
      if (wr_ok & hit_antd) antd_reg <= merge16(antd_reg, i_pwdata, i_pstrb); // RQ11
      if (wr_ok & hit_cfg2) cfg2_reg <= merge16(cfg2_reg, i_pwdata, i_pstrb);
      if (wr_ok & hit_repc) repc_reg <= merge16(repc_reg, i_pwdata, i_pstrb);
    end
  end

  // analysis sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (i_rx_start) state_next = ST_SCAN;
      ST_SCAN: if (tap & i_sample.last) state_next = ST_FIN; // RQ1
      ST_FIN:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // running scan: peak search and first threshold crossing
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      thresh_reg   <= 21'h000000;
      raw_reg      <= {TS_W{1'b0}};
      cnt_reg      <= 16'h0000;
      pidx_run_reg <= 16'h0000;
      pamp_run_reg <= 16'h0000;
      fidx_reg     <= 16'h0000;
      famp_reg     <= 16'h0000;
      found_reg    <= 1'b0;
    end else if (state_reg == ST_IDLE && i_rx_start) begin
      thresh_reg   <= thr_calc; // RQ5 RQ7
      raw_reg      <= i_raw_ts;
      cnt_reg      <= 16'h0000;
      pidx_run_reg <= 16'h0000;
      pamp_run_reg <= 16'h0000;
      found_reg    <= 1'b0;
    end else if (tap) begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (new_peak) begin
        pidx_run_reg <= pidx_fin; // RQ9
        pamp_run_reg <= i_sample.mag; // RQ10
      end
      if (crossing) begin
        found_reg <= 1'b1; // RQ1
        fidx_reg  <= cnt_reg;
        famp_reg  <= i_sample.mag;
      end
    end
  end

  // results published once per frame at end of analysis
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ppindx_reg <= 16'h0000;
      ppampl_reg <= 16'h0000;
      o_rx_stamp <= {TS_W{1'b0}};
      o_diag     <= '0;
      o_done     <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      o_done <= state_reg == ST_FIN;
      o_busy <= state_next != ST_IDLE;
      if (state_reg == ST_FIN) begin
        ppindx_reg <= pidx_run_reg; // RQ9 RQ15
        ppampl_reg <= pamp_run_reg; // RQ10
        o_rx_stamp <= stamp_val; // RQ2
        o_diag     <= '{found: found_reg, first_idx: fidx_sel,
                        first_amp: famp_sel, threshold: thr_sat}; // RQ3
      end
    end
  end

  // checks
  a_ready_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_ready_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && !o_pready) |=> o_pready)
    else $error("pready not given after one wait state");
  a_thresh_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
    (state_reg == ST_IDLE && i_rx_start) |=> thresh_reg == $past(thr_calc))
    else $error("threshold not loaded from multipliers");
  a_cfg1_lane: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ8
    (wr_ok && hit_cfg1 && !i_pstrb[0]) |=> $stable(cfg1_reg))
    else $error("config one changed without its byte lane");
  a_peak_track: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ10
    new_peak |=> (pamp_run_reg == $past(i_sample.mag)) &&
                 (pidx_run_reg == $past(cnt_reg)))
    else $error("peak tracker missed a larger tap");
  a_result_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ15
    (state_reg != ST_FIN) |=> $stable(ppindx_reg) && $stable(o_rx_stamp))
    else $error("results changed outside end of analysis");
  a_stamp_calc: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ13
    (state_reg == ST_FIN) |=> o_rx_stamp == $past(raw_reg - antd_ext - fp_corr))
    else $error("adjusted stamp wrong");
  a_first_order: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ14
    o_done |-> o_diag.first_idx <= ppindx_reg)
    else $error("first path after peak");
  a_done_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ2
    o_done |=> !o_done ##1 !o_done)
    else $error("done not a single pulse");
  a_antd_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ11
    (wr_ok && hit_antd && i_pstrb[1:0] == 2'b11) |=> antd_reg == $past(i_pwdata[15:0]))
    else $error("antenna delay write lost");

  // bus answer checks: refusals only ever ride on an answer cycle
  a_err_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ4
    o_pslverr |-> o_pready)
    else $error("error flagged outside an answer cycle");
  a_err_unmapped: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ4
    (acc_ph && !o_pready && !mapped) |=> o_pslverr && (o_prdata == 32'h0000_0000))
    else $error("reserved location not refused");

  // register file checks: writes land only where they belong
  a_cfg1_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
    wr_cfg1 |=> cfg1_reg == $past(i_pwdata[7:0]))
    else $error("config one byte write lost");
  a_antd_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ11
    !(wr_ok && hit_antd) |=> $stable(antd_reg))
    else $error("antenna delay changed without a write");
  a_ro_index: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ9
    (wr_ok && hit_pidx && state_reg != ST_FIN) |=> $stable(ppindx_reg))
    else $error("peak index register took a write");
  a_ro_amp: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ10
    (wr_ok && hit_pamp && state_reg != ST_FIN) |=> $stable(ppampl_reg))
    else $error("peak amplitude register took a write");

  // scan checks: capture at start, tap counting, peak and crossing search
  a_raw_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ2
    (state_reg == ST_IDLE && i_rx_start) |=> raw_reg == $past(i_raw_ts))
    else $error("raw stamp not captured at start");
  a_busy_start: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
    (state_reg == ST_IDLE && i_rx_start) |=> o_busy && (state_reg == ST_SCAN))
    else $error("start not taken while idle");
  a_busy_scan: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
    (state_reg == ST_SCAN) |-> o_busy)
    else $error("busy low during scan");
  a_tap_count: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ9
    tap |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("tap index not advanced");
  a_peak_max: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ10
    tap |=> pamp_run_reg >= $past(i_sample.mag))
    else $error("running peak below a seen tap");
  a_first_cross: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
    crossing |=> found_reg && (fidx_reg == $past(cnt_reg)))
    else $error("first crossing not recorded");
  a_found_above: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
    found_reg |-> {5'h00, famp_reg} > thresh_reg)
    else $error("first path not above threshold");
  a_idle_ignore: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ15
    (state_reg == ST_IDLE && !i_rx_start) |=> $stable(pamp_run_reg) && $stable(pidx_run_reg))
    else $error("scan state moved while idle");
  a_scan_end: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
    (tap && i_sample.last) |=> (state_reg == ST_FIN) ##1 o_done)
    else $error("last tap did not end the scan");

  // result checks: published set is consistent
  a_done_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ15
    o_done |-> !o_busy)
    else $error("busy still high with done");
  a_first_amp: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ3
    o_done |-> o_diag.first_amp <= ppampl_reg)
    else $error("first path amplitude above peak");
endmodule

// ===== ledr_tb_top.sv
// Purpose: self-checking bench for the leading edge detect block
// Assumes: apb answers after a bounded wait; taps streamed after a start pulse
// Notes:   register rows first, then a refusal, frames and a second reset
module ledr_tb_top
  import ledr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [17:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } ledr_row_t;
  logic            clk, rst, psel, penable, pwrite, rx_start, done, busy, pready, pslverr;
  logic [17:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      pstrb;
  logic [15:0]     nlev, npk;
  logic [TS_W-1:0] raw, stamp;
  ledr_sample_t    smp;
  ledr_diag_t      diag;
  logic            err;
  int              miscompares, comparisons;
  ledr_row_t       rows [7];
  ledr_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_start(rx_start),
    .i_noise_level(nlev), .i_noise_peak(npk), .i_raw_ts(raw), .i_sample(smp),
    .o_rx_stamp(stamp), .o_diag(diag), .o_done(done), .o_busy(busy));
  // clock source
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk40(input logic [TS_W-1:0] got, input logic [TS_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready seen at an edge
  task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // idle edge so the next call never drives psel twice at one instant
  endtask
  // one frame: start pulse, taps, bounded wait for done
  task automatic frame(input logic [15:0] nl, input logic [15:0] np,
                       input logic [TS_W-1:0] r, input logic [15:0] m [5]);
    int n;
    nlev <= nl;
    npk <= np;
    raw <= r;
    rx_start <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      smp <= '{1'b1, k == 4, m[k]};
      rx_start <= (k == 2); // start while busy must be ignored
      if (k == 1) chk32(busy, 32'h1);
      @(posedge clk);
    end
    smp <= '0;
    rx_start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk32(n, 2);
    chk32(busy, 32'h0);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  initial begin
    {psel, penable, pwrite, rx_start, paddr, pwdata, pstrb, nlev, npk, raw, smp} = '0;
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rows[0] = '{18'h02018, 32'h0000006D, 4'h1, 32'h0000006D};
    rows[1] = '{18'h02018, 32'hFFFFFF2C, 4'h2, 32'h0000006D};
    rows[2] = '{18'h06010, 32'h00001234, 4'h3, 32'h00001234};
    rows[3] = '{18'h06018, 32'h00001607, 4'hF, 32'h00001607};
    rows[4] = '{18'h0A010, 32'h00005998, 4'hF, 32'h00005998};
    rows[5] = '{18'h04000, 32'h0000ABCD, 4'hF, 32'h00000000};
    rows[6] = '{18'h04008, 32'h0000FFFF, 4'hF, 32'h00000000};
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d, rows[i].s);
      apb(rows[i].a, 1'b0, 32'h0, 4'h0);
      chk32(rd, rows[i].e);
    end
    $display("register rows done");
    apb(18'h00004, 1'b0, 32'h0, 4'h0);
    chk32({err, rd[30:0]}, 32'h80000000);
    // threshold 150 from peak 100*3/2 over noise 10*13; first 2, peak 3
    frame(16'd10, 16'd100, 40'h1000000000, '{16'd50, 16'd100, 16'd200, 16'd500, 16'd300});
    chk40(stamp, 40'h1000000000 - 40'h1234 - (40'd1 << TAP_SHIFT));
    chk32({diag.found, diag.first_idx}, {15'h0, 1'b1, 16'd2});
    chk32({diag.first_amp, diag.threshold}, {16'd200, 16'd150});
    apb(18'h04000, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'd3);
    apb(18'h04008, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'd500);
    apb(18'h00000, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'd150);
    apb(18'h0C000, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'h00020002);
    chk40(stamp, 40'h1000000000 - 40'h1274);
    $display("first frame done");
    // threshold 6000*13 saturates, no tap crosses: first path is peak, stamp wraps
    frame(16'd6000, 16'd0, 40'h0, '{16'd5, 16'd9, 16'd7, 16'd3, 16'd2});
    chk40(stamp, 40'hFFFFFFEDCC);
    chk32({diag.found, diag.first_idx}, {15'h0, 1'b0, 16'd1});
    chk32({diag.first_amp, diag.threshold}, {16'd9, 16'hFFFF});
    apb(18'h04008, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'd9);
    $display("second frame done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk40(stamp, 40'h0);
    apb(18'h02018, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'h0000006C);
    apb(18'h06010, 1'b0, 32'h0, 4'h0);
    chk32(rd, 32'h0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
